// [sim/adc_port_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"
module adc_port_props #(
  parameter SAMPLE_W = 16,
  parameter LATENCY = 6,
  parameter NAP_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic encode_in_pos,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic convert_ready,
  input wire logic conversion_start,
  input wire logic [SAMPLE_W-1:0] data_out,
  input wire logic [SAMPLE_W-1:0] data_oe,
  input wire logic range_exceeded_flag,
  input wire logic range_exceeded_flag_neg,
  input wire logic range_flag_neg_oe,
  input wire logic sample_out_clk_pos,
  input wire logic sample_out_clk_neg,
  input wire logic [1:0] out_mode,
  input wire logic [1:0] power_mode,
  input wire logic nap_active
);
  logic [2:0] up;
  logic [15:0] quiet;
  logic enc_q;
  // The settle counter keeps $past from looking back into reset.
  always @(posedge clk) begin
    enc_q <= encode_in_pos;
    up <= rst ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
    quiet <= (rst || encode_in_pos != enc_q) ? 16'h0 : quiet + 16'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence settled;
    up == 3'h7 && out_mode == $past(out_mode) && out_mode == $past(out_mode, 2);
  endsequence
  sequence live;
    convert_ready && !nap_active && power_mode == `PWR_ON;
  endsequence
  sequence enc_taken;
    $rose(encode_in_pos) && up == 3'h7 ##0 live ##1 live [*2];
  endsequence
  a_start_on_encode: assert property (enc_taken |-> ##[0:5] conversion_start)
    else $error("no conversion start");
  a_clk_pair_inverse: assert property (sample_out_clk_neg == !sample_out_clk_pos)
    else $error("clock pair not inverse");
  a_sdo_pulls_low: assert property (sdo_oe |-> sdo_out == 1'b0)
    else $error("sdo driven high");
  a_ddr_pins_free: assert property (settled ##0 out_mode == `OUT_DDR_CMOS |->
    data_oe == 16'haaaa) else $error("ddr pin enables");
  a_full_data_edge: assert property (settled ##0 (out_mode == `OUT_FULL_CMOS
    && data_out != $past(data_out)) |-> !sample_out_clk_pos) else $error("full edge");
  a_ddr_data_edge: assert property (settled ##0 (out_mode != `OUT_FULL_CMOS
    && data_out != $past(data_out)) |-> $changed(sample_out_clk_pos)) else $error("ddr edge");
  a_lvds_flag_pair: assert property (settled ##0 out_mode == `OUT_DDR_LVDS |->
    range_flag_neg_oe && range_exceeded_flag_neg == !range_exceeded_flag) else $error("lvds flag");
  a_lvds_data_pair: assert property (settled ##0 out_mode == `OUT_DDR_LVDS |->
    (((data_out >> 1) ^ data_out) & 16'h5555) == 16'h5555) else $error("lvds data pair");
  a_nap_when_idle: assert property (quiet >= NAP_CYC + 8 && power_mode == `PWR_ON |->
    nap_active) else $error("no nap");
endmodule // adc_port_props
bind adc_output_and_config_port adc_port_props #(.SAMPLE_W(SAMPLE_W), .LATENCY(LATENCY),
  .NAP_CYC(NAP_CYC)) props (.clk(clk), .rst(rst), .encode_in_pos(encode_in_pos),
  .sdo_out(sdo_out), .sdo_oe(sdo_oe), .convert_ready(convert_ready),
  .conversion_start(conversion_start), .data_out(data_out), .data_oe(data_oe),
  .range_exceeded_flag(range_exceeded_flag), .range_exceeded_flag_neg(range_exceeded_flag_neg),
  .range_flag_neg_oe(range_flag_neg_oe), .sample_out_clk_pos(sample_out_clk_pos),
  .sample_out_clk_neg(sample_out_clk_neg), .out_mode(out_mode), .power_mode(power_mode),
  .nap_active(nap_active));
`default_nettype wire

// [sim/sample_capture.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"
module sample_capture (
  input wire logic clk,
  input wire logic stall,
  input wire logic [1:0] out_mode,
  input wire logic [15:0] data_out,
  input wire logic flag,
  input wire logic ck,
  output logic ready
);
  logic ck_q;
  logic f_q;
  logic [3:0] calm = 4'h0;
  logic [15:0] d_q;
  logic [15:0] lo;
  logic [15:0] w;
  logic [16:0] got[$];
  assign ready = !stall;
  // Only the output clock is trusted, so a wrong phase shows up as wrong words.
  // A stall leaves the last word on the pins while the clock runs on, so words
  // are kept only once the stall has been off longer than a load takes to show.
  always @(posedge clk) begin
    ck_q <= ck;
    d_q <= data_out;
    f_q <= flag;
    calm <= stall ? 4'h0 : (calm == 4'hf ? calm : calm + 4'h1);
    if (ck && !ck_q) begin
      if (out_mode == `OUT_FULL_CMOS) begin
        if (calm >= 4'hc) got.push_back({flag, data_out});
      end else begin
        lo <= d_q;
      end
    end
    if (!ck && ck_q && out_mode != `OUT_FULL_CMOS && calm >= 4'hc) begin
      for (int k = 0; k < 8; k++) begin
        w[2*k] = lo[2*k+1];
        w[2*k+1] = d_q[2*k+1];
      end
      got.push_back({f_q, w});
    end
  end
endmodule // sample_capture
`default_nettype wire

// [sim/test_adc_output_and_config_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"
module test_adc_output_and_config_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enc = 1'b0;
  logic enc_run = 1'b0;
  logic strap = 1'b0;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic sdi = 1'b0;
  logic sdo_drv = 1'b1;
  logic stall = 1'b0;
  logic over = 1'b0;
  logic under = 1'b0;
  logic diff = 1'b0;
  logic [7:0] seq = 8'h00;
  logic [15:0] sample = 16'h00ff;
  int err_total = 0;
  int samples_checked = 0;
  wire sdo_out, sdo_oe, cv_rdy, cv_start, flag, flag_n, flag_n_oe, ck_p, ck_n;
  wire dcs_enable, nap_active, lvds_term, ready;
  wire [15:0] data_out, data_oe;
  wire [1:0] out_mode, power_mode;
  wire [2:0] lvds_current;
  // Pull-up on the open-drain line unless someone pulls it low.
  wire sdo_line = sdo_oe ? 1'b0 : sdo_drv;
  // One stream runs with differential encode; otherwise the complement is grounded.
  wire enc_n = diff & ~enc;
  adc_output_and_config_port #(.NAP_CYC(10)) DUT (.clk(clk), .rst(rst), .ce(1'b1),
    .encode_in_pos(enc), .encode_in_neg(enc_n), .prog_mode_strap(strap), .cs_n(cs_n),
    .sck(sck), .sdi(sdi), .sdo_in(sdo_line), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .sample_in(sample), .over_range(over), .under_range(under), .convert_ready(cv_rdy),
    .conversion_start(cv_start), .sample_out_ready(ready), .data_out(data_out),
    .data_oe(data_oe), .range_exceeded_flag(flag), .range_exceeded_flag_neg(flag_n),
    .range_flag_neg_oe(flag_n_oe), .sample_out_clk_pos(ck_p), .sample_out_clk_neg(ck_n),
    .out_mode(out_mode), .dcs_enable(dcs_enable), .power_mode(power_mode),
    .nap_active(nap_active), .lvds_current(lvds_current), .lvds_term(lvds_term));
  sample_capture cap (.clk(clk), .stall(stall), .out_mode(out_mode), .data_out(data_out),
    .flag(flag), .ck(ck_p), .ready(ready));
  initial begin
    forever #20 clk = ~clk;
  end
  // The sample changes mid low phase, well clear of the synchronised rise.
  always begin
    @(negedge clk);
    if (enc_run) begin
      enc = 1'b1;
      repeat (4) @(negedge clk);
      enc = 1'b0;
      repeat (2) @(negedge clk);
      seq = seq + 8'h01;
      sample = {seq, ~seq};
      over = (seq[3:0] == 4'h5);
      under = (seq[3:0] == 4'h9);
      @(negedge clk);
    end
  end
  task automatic chk(input logic [16:0] seen, input logic [16:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t %s %h %h", $time, what, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic spi(input logic sel_n, input logic [7:0] hdr, input logic [7:0] d,
                     output logic [7:0] q);
    q = 8'h00;
    @(negedge clk);
    cs_n = sel_n;
    for (int i = 15; i >= 0; i--) begin
      sdi = i > 7 ? hdr[i-8] : d[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      if (i < 8) q[i] = sdo_line;
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic check_words(input logic gap, input int min_n);
    logic [16:0] w;
    logic [7:0] prev;
    chk({16'h0, cap.got.size() >= min_n}, 17'h1, "count");
    foreach (cap.got[i]) begin
      w = cap.got[i];
      chk({9'h0, w[7:0]}, {9'h0, ~w[15:8]}, "bits");
      chk({16'h0, w[16]}, {16'h0, w[11:8] == 4'h5 || w[11:8] == 4'h9}, "ovf");
      if (i > 0) chk({16'h0, gap ? w[15:8] > prev : w[15:8] == prev + 8'h01}, 17'h1, "order");
      prev = w[15:8];
    end
  endtask
  task automatic t_serial;
    logic [7:0] q;
    spi(1'b0, 8'h03, 8'h2a, q);
    chk({13'h0, lvds_term, lvds_current}, {13'h0, 4'ha}, "lvds");
    spi(1'b0, 8'h83, 8'h00, q);
    chk({9'h0, q}, 17'h0002a, "read");
    spi(1'b0, 8'h85, 8'h00, q);
    chk({9'h0, q}, 17'h0, "unmapped");
    spi(1'b0, 8'h02, 8'h01, q);
    spi(1'b1, 8'h02, 8'h00, q);
    chk({16'h0, dcs_enable}, 17'h1, "deselect");
    $display("t_serial done");
  endtask
  task automatic t_stream(input logic [7:0] a3, input logic [1:0] mode, input logic gap);
    logic [7:0] q;
    spi(1'b0, 8'h03, a3, q);
    chk({15'h0, out_mode}, {15'h0, mode}, "format");
    enc_run = 1'b1;
    repeat (80) @(negedge clk);
    cap.got.delete();
    stall = gap;
    repeat (64) @(negedge clk);
    if (gap) chk({16'h0, cv_rdy}, 17'h0, "full");
    stall = 1'b0;
    repeat (96) @(negedge clk);
    enc_run = 1'b0;
    repeat (40) @(negedge clk);
    check_words(gap, 10);
    chk({16'h0, nap_active}, 17'h1, "nap");
    $display("t_stream %0d done", mode);
  endtask
  task automatic t_parallel;
    strap = 1'b1;
    sck = 1'b1;
    sdi = 1'b0;
    sdo_drv = 1'b1;
    do_reset();
    chk({14'h0, dcs_enable, out_mode}, {14'h0, 1'b1, `OUT_DDR_LVDS}, "par");
    chk({15'h0, power_mode}, {15'h0, `PWR_NAP}, "par nap");
    cs_n = 1'b0;
    sck = 1'b0;
    sdo_drv = 1'b0;
    sdi = 1'b1;
    repeat (8) @(negedge clk);
    chk({14'h0, dcs_enable, out_mode}, {14'h0, 1'b0, `OUT_FULL_CMOS}, "par b");
    chk({16'h0, power_mode[1]}, 17'h1, "par sleep");
    $display("t_parallel done");
  endtask
  initial begin
    do_reset();
    t_serial();
    t_stream(8'h2a, `OUT_DDR_CMOS, 1'b0);
    diff = 1'b1;
    t_stream(8'h15, `OUT_DDR_LVDS, 1'b0);
    diff = 1'b0;
    t_stream(8'h03, `OUT_FULL_CMOS, 1'b0);
    t_stream(8'h03, `OUT_FULL_CMOS, 1'b1);
    t_parallel();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("BAD %0t watchdog", $time);
    tally_and_finish();
  end
endmodule // test_adc_output_and_config_port
`default_nettype wire

// [src/adc_output_and_config_port.v]
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"

// What this block does
// [R1] A conversion starts on each encode rising edge or complement falling edge; here none starts on an edge that finds the output buffer full.
// [R2] For single-ended encode the outside holds the complement input at ground.
// [R3] Strap low: the four configuration pins form a serial mode interface.
// [R4] Strap high: the four pins are static inputs for a reduced mode set.
// [R5] Serial data shifts into mode registers only while chip select is low.
// [R6] Serial input is sampled on the rising serial clock edge.
// [R7] Readback drives register bits on serial out for falling-edge capture.
// [R8] Serial out is open drain and only pulls low.
// [R9] Parallel mode: chip select enables the duty cycle stabilizer.
// [R10] Parallel mode: serial clock pin selects the output format.
// [R11] Parallel mode: serial in and serial out pins select power-down states.
// [R12] Full-rate format shows all sixteen bits, bit 15 most significant.
// [R13] Full-rate data changes with the falling output clock edge.
// [R14] The negative output clock is always the inverse of the positive.
// [R15] The output clock phase can be delayed by a mode register setting.
// [R16] DDR CMOS puts two bits on each of eight pins, others released.
// [R17] DDR shows even bits while output clock is low, odd while high.
// [R18] DDR data changes on both output clock edges.
// [R19] LVDS carries bit pairs, overflow and clock on differential pairs.
// [R20] LVDS offers programmable driver current and optional internal termination.
// [R21] The overflow flag is high when the input is out of range.
// [R22] Latency is six encode cycles full rate, six and a half DDR.
// [R23] Overflow has the same pipeline delay as its sample bits.
// [R24] DDR CMOS cannot be chosen in parallel programming mode.
// [R25] Nap is entered when the encode clock stops or runs too slowly.
// [R26] Chip select high leaves mode registers untouched by serial activity.
// [R27] Capture logic samples data and overflow on the output clock edges.
module adc_output_and_config_port #(
  parameter SAMPLE_W = `SAMPLE_W,
  parameter LATENCY = `FULL_LATENCY,
  parameter NAP_CYC = `NAP_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire encode_in_pos,
  input wire encode_in_neg,
  input wire prog_mode_strap,
  input wire cs_n,
  input wire sck,
  input wire sdi,
  input wire sdo_in,
  output reg sdo_out,
  output reg sdo_oe,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire over_range,
  input wire under_range,
  output reg convert_ready,
  output reg conversion_start,
  input wire sample_out_ready,
  output reg [SAMPLE_W-1:0] data_out,
  output reg [SAMPLE_W-1:0] data_oe,
  output reg range_exceeded_flag,
  output reg range_exceeded_flag_neg,
  output reg range_flag_neg_oe,
  output reg sample_out_clk_pos,
  output reg sample_out_clk_neg,
  output reg [1:0] out_mode,
  output reg dcs_enable,
  output reg [1:0] power_mode,
  output reg nap_active,
  output reg [2:0] lvds_current,
  output reg lvds_term
);

  localparam PIPE_W = SAMPLE_W + 2;

  // Every encode and configuration pin input passes two flip-flops before any logic sees it; sample and range inputs do not.
  reg [6:0] sync1;
  reg [6:0] sync2;
  wire s_enc_pos = sync2[0];
  wire s_enc_neg = sync2[1];
  wire s_strap = sync2[2];
  wire s_cs_n = sync2[3];
  wire s_sck = sync2[4];
  wire s_sdi = sync2[5];
  wire s_sdo = sync2[6];

  always @(posedge clk) begin
    if (rst) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else if (ce) begin
      sync1 <= {sdo_in, sdi, sck, cs_n, prog_mode_strap, encode_in_neg, encode_in_pos};
      sync2 <= sync1;
    end
  end

  // With the complement grounded this is just the positive input, so one
  // detector serves both differential and single-ended drive.
  wire enc_lvl = s_enc_pos & ~s_enc_neg; // see [R2]
  reg enc_prev;
  reg enc_d2;
  reg sck_prev;
  reg rise_d;
  reg fall_d;
  wire enc_rise = enc_lvl & ~enc_prev; // see [R1]
  wire enc_fall = ~enc_lvl & enc_prev;
  wire sck_rise = s_sck & ~sck_prev; // see [R6]
  wire sck_fall = ~s_sck & sck_prev; // see [R7]

  always @(posedge clk) begin
    if (rst) begin
      enc_prev <= 1'b0;
      enc_d2 <= 1'b0;
      sck_prev <= 1'b0;
      rise_d <= 1'b0;
      fall_d <= 1'b0;
    end else if (ce) begin
      enc_prev <= enc_lvl;
      enc_d2 <= enc_prev;
      sck_prev <= s_sck;
      rise_d <= enc_rise;
      fall_d <= enc_fall;
    end
  end

  // The strap is a board tie, so it is caught once, after the synchroniser
  // has filled following reset, and never followed again.
  reg [1:0] strap_wait;
  reg serial_mode;

  always @(posedge clk) begin
    if (rst) begin
      strap_wait <= 2'h0;
      serial_mode <= 1'b1;
    end else if (ce && strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        serial_mode <= ~s_strap; // see [R3] [R4]
      end
    end
  end

  // Serial configuration engine.
  reg [7:0] mreg [0:3];
  reg [`BIT_CNT_W-1:0] bit_cnt;
  reg [14:0] shifter;
  reg rw_l;
  reg [6:0] addr_l;
  reg rd_act;
  reg [7:0] rd_sh;
  wire [6:0] hdr_addr = {shifter[5:0], s_sdi};
  wire frame_open = serial_mode & ~s_cs_n;
  integer i;

  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        mreg[i] <= `MREG_RESET;
      end
      bit_cnt <= {`BIT_CNT_W{1'b0}};
      shifter <= 15'h0000;
      rw_l <= 1'b0;
      addr_l <= 7'h00;
      rd_act <= 1'b0;
      rd_sh <= 8'h00;
      sdo_oe <= 1'b0;
      sdo_out <= 1'b0;
    end else if (ce) begin
      sdo_out <= 1'b0; // see [R8]
      if (!frame_open) begin
        bit_cnt <= {`BIT_CNT_W{1'b0}}; // see [R26]
        rd_act <= 1'b0;
        sdo_oe <= 1'b0;
      end else begin
        if (sck_rise) begin
          shifter <= {shifter[13:0], s_sdi}; // see [R5] [R6]
          if (bit_cnt == `FRAME_LAST) begin
            bit_cnt <= {`BIT_CNT_W{1'b0}};
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (bit_cnt == `HDR_LAST) begin
            rw_l <= shifter[6];
            addr_l <= hdr_addr;
            rd_act <= shifter[6];
            if (hdr_addr < `NREG) begin
              rd_sh <= mreg[hdr_addr[1:0]];
            end else begin
              rd_sh <= 8'h00;
            end
          end
          if (bit_cnt == `FRAME_LAST && !rw_l && addr_l < `NREG) begin
            mreg[addr_l[1:0]] <= {shifter[6:0], s_sdi}; // see [R5]
          end
        end
        if (sck_fall && rd_act) begin
          // Only a zero pulls the line; a one is left to the pull-up.
          sdo_oe <= ~rd_sh[7]; // see [R7] [R8]
          rd_sh <= {rd_sh[6:0], 1'b0};
        end
      end
    end
  end

  // Encode activity watch.
  reg [`NAP_CNT_W-1:0] idle_cnt;
  wire enc_slow = (idle_cnt >= NAP_CYC);

  always @(posedge clk) begin
    if (rst) begin
      idle_cnt <= {`NAP_CNT_W{1'b0}};
    end else if (ce) begin
      if (enc_rise) begin
        idle_cnt <= {`NAP_CNT_W{1'b0}};
      end else if (!enc_slow) begin
        idle_cnt <= idle_cnt + 12'h001;
      end
    end
  end

  // Effective configuration, from registers or from the static pins.
  reg [1:0] clk_phase;

  always @(posedge clk) begin
    if (rst) begin
      dcs_enable <= 1'b0;
      out_mode <= `OUT_FULL_CMOS;
      power_mode <= `PWR_ON;
      clk_phase <= 2'h0;
      lvds_current <= `CUR_DEFAULT;
      lvds_term <= 1'b0;
      nap_active <= 1'b0;
    end else if (ce) begin
      if (serial_mode) begin
        dcs_enable <= mreg[`REG_A2][`DCS_BIT];
        clk_phase <= mreg[`REG_A2][`PHASE_HI:`PHASE_LO]; // see [R15]
        power_mode <= mreg[`REG_A1][`PD_HI:`PD_LO];
        if (mreg[`REG_A3][`MODE_HI:`MODE_LO] == `OUT_DDR_LVDS ||
            mreg[`REG_A3][`MODE_HI:`MODE_LO] == `OUT_DDR_CMOS) begin
          out_mode <= mreg[`REG_A3][`MODE_HI:`MODE_LO];
        end else begin
          out_mode <= `OUT_FULL_CMOS;
        end
        lvds_current <= mreg[`REG_A3][`CUR_HI:`CUR_LO]; // see [R20]
        lvds_term <= mreg[`REG_A3][`TERM_BIT]; // see [R20]
      end else begin
        dcs_enable <= s_cs_n; // see [R9]
        // Only two formats reach the pin, so DDR CMOS is out of reach here.
        out_mode <= s_sck ? `OUT_DDR_LVDS : `OUT_FULL_CMOS; // see [R10] [R24]
        if (s_sdi) begin
          power_mode <= `PWR_SLEEP; // see [R11]
        end else if (s_sdo) begin
          power_mode <= `PWR_NAP; // see [R11]
        end else begin
          power_mode <= `PWR_ON;
        end
        clk_phase <= 2'h0;
        lvds_current <= `CUR_DEFAULT;
        lvds_term <= 1'b0;
      end
      nap_active <= enc_slow | (power_mode != `PWR_ON); // see [R25]
    end
  end

  // Conversion pipeline: one stage per encode cycle, stalled while the
  // output buffer is full so that no finished sample is dropped.
  reg [PIPE_W-1:0] pipe [0:LATENCY-1];
  wire buf_in_ready;
  wire buf_out_valid;
  wire [SAMPLE_W:0] buf_out_data;
  wire conv_go = enc_rise & buf_in_ready;
  wire conv_live = (power_mode == `PWR_ON) & ~nap_active;
  wire flag_now = over_range | under_range;
  integer j;

  always @(posedge clk) begin
    if (rst) begin
      for (j = 0; j < LATENCY; j = j + 1) begin
        pipe[j] <= {PIPE_W{1'b0}};
      end
      conversion_start <= 1'b0;
      convert_ready <= 1'b0;
    end else if (ce) begin
      conversion_start <= conv_go & conv_live;
      convert_ready <= buf_in_ready;
      if (conv_go) begin
        pipe[0] <= {conv_live, flag_now, sample_in}; // see [R1] [R21]
        for (j = 1; j < LATENCY; j = j + 1) begin
          pipe[j] <= pipe[j-1]; // see [R22] [R23]
        end
      end
    end
  end

  // Full rate releases a word with the rising encode edge, DDR with the
  // following falling one, which adds the half cycle.
  wire is_ddr = (out_mode != `OUT_FULL_CMOS);
  wire load_evt = is_ddr ? fall_d : rise_d; // see [R22]
  wire drain = load_evt & sample_out_ready;

  two_entry_buffer #(
    .WIDTH(SAMPLE_W + 1)
  ) out_buffer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(conv_go & pipe[LATENCY-1][PIPE_W-1]),
    .in_ready(buf_in_ready),
    .in_data(pipe[LATENCY-1][SAMPLE_W:0]),
    .out_valid(buf_out_valid),
    .out_ready(drain),
    .out_data(buf_out_data)
  );

  reg [SAMPLE_W:0] shown;

  always @(posedge clk) begin
    if (rst) begin
      shown <= {(SAMPLE_W + 1){1'b0}};
    end else if (ce && drain && buf_out_valid) begin
      shown <= buf_out_data;
    end
  end

  // Pin mapping per bit pair.
  wire is_lvds = (out_mode == `OUT_DDR_LVDS);
  wire is_ddr_cmos = (out_mode == `OUT_DDR_CMOS);
  wire [SAMPLE_W-1:0] next_data;
  wire [SAMPLE_W-1:0] next_oe;
  genvar k;

  generate
    for (k = 0; k < SAMPLE_W / 2; k = k + 1) begin : lane
      wire pair_bit = enc_d2 ? shown[2*k+1] : shown[2*k]; // see [R17] [R18]
      assign next_data[2*k+1] = is_ddr ? pair_bit : shown[2*k+1]; // see [R12] [R16]
      assign next_data[2*k] = is_lvds ? ~pair_bit : (is_ddr ? 1'b0 : shown[2*k]); // see [R19]
      assign next_oe[2*k+1] = 1'b1;
      assign next_oe[2*k] = ~is_ddr_cmos; // see [R16]
    end
  endgenerate

  // Output clock: data follows the undelayed source, the clock may lag it.
  wire clk_src = is_ddr ? enc_d2 : ~enc_d2; // see [R13] [R18]
  reg [2:0] clk_delay;
  reg next_clk;

  always @* begin
    case (clk_phase)
      2'h0: next_clk = clk_src;
      2'h1: next_clk = clk_delay[0];
      2'h2: next_clk = clk_delay[1];
      2'h3: next_clk = clk_delay[2];
      default: next_clk = clk_src;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      clk_delay <= 3'h0;
      sample_out_clk_pos <= 1'b0;
      sample_out_clk_neg <= 1'b1;
      data_out <= {SAMPLE_W{1'b0}};
      data_oe <= {SAMPLE_W{1'b0}};
      range_exceeded_flag <= 1'b0;
      range_exceeded_flag_neg <= 1'b0;
      range_flag_neg_oe <= 1'b0;
    end else if (ce) begin
      clk_delay <= {clk_delay[1:0], clk_src};
      sample_out_clk_pos <= next_clk; // see [R15]
      sample_out_clk_neg <= ~next_clk; // see [R14]
      data_out <= next_data;
      data_oe <= next_oe;
      range_exceeded_flag <= shown[SAMPLE_W]; // see [R21] [R23]
      range_exceeded_flag_neg <= is_lvds & ~shown[SAMPLE_W]; // see [R19]
      range_flag_neg_oe <= is_lvds;
    end
  end

endmodule // adc_output_and_config_port

`default_nettype wire

// [src/adc_port_defines.vh]
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// Sample word and pipeline.
`define SAMPLE_W 16
`define FULL_LATENCY 6

// Clock and nap detection timing.
`define CLK_PERIOD_NS 40
`define NAP_PERIOD_NS 2000
`define NAP_CYCLES (`NAP_PERIOD_NS / `CLK_PERIOD_NS)
`define NAP_CNT_W 12

// Serial frame: one direction bit, seven address bits, eight data bits.
`define BIT_CNT_W 5
`define HDR_LAST 5'h07
`define FRAME_LAST 5'h0f

// Mode control register addresses and reset value.
`define NREG 7'h04
`define REG_A1 2'h1
`define REG_A2 2'h2
`define REG_A3 2'h3
`define MREG_RESET 8'h00

// Field positions inside the mode control registers.
`define PD_HI 1
`define PD_LO 0
`define DCS_BIT 0
`define PHASE_HI 2
`define PHASE_LO 1
`define MODE_HI 1
`define MODE_LO 0
`define CUR_HI 4
`define CUR_LO 2
`define TERM_BIT 5

// Output formats.
`define OUT_FULL_CMOS 2'h0
`define OUT_DDR_LVDS 2'h1
`define OUT_DDR_CMOS 2'h2

// Power states.
`define PWR_ON 2'h0
`define PWR_NAP 2'h1
`define PWR_SLEEP 2'h2

// Default driver current code and buffer depth.
`define CUR_DEFAULT 3'h0
`define BUF_DEPTH 2'h2

`endif

// [src/two_entry_buffer.v]
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_defines.vh"

module two_entry_buffer #(
  parameter WIDTH = 17
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != `BUF_DEPTH);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      case ({push, pop})
        2'b10: count <= count + 2'h1;
        2'b01: count <= count - 2'h1;
        default: count <= count;
      endcase
    end
  end

endmodule // two_entry_buffer

`default_nettype wire
